/* uhp_pkg.sv */
package uhp_pkg;

	// Register byte addresses on the APB side
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFDF0; // Sticky event flags, write one to clear
	localparam logic [15:0] ADDR_IRQ_MASK   = 16'hFDF4; // Interrupt mask, same layout as status
	localparam logic [15:0] ADDR_INTSEL     = 16'hFDF8; // Interrupt line source select
	localparam logic [15:0] ADDR_HUB_OC     = 16'hFDFC; // Hub overcurrent control
	localparam logic [15:0] ADDR_PORT_PWR   = 16'hFDE0; // Port power switch and live overcurrent view

	// Reset values
	localparam logic [7:0] RST_HUB_OC   = 8'h00;
	localparam logic [7:0] RST_INTSEL   = 8'h00;
	localparam logic [5:0] RST_IRQ      = 6'h00;
	localparam logic [3:0] RST_PORT_PWR = 4'h0;

	// Field layout of the interrupt status and mask registers
	localparam int IRQ_BIT_LINE_B = 0; // Line B pulsed
	localparam int IRQ_BIT_LINE_C = 1; // Line C pulsed
	localparam int IRQ_BIT_OC0    = 2; // Overcurrent on port 2, ports 3..5 follow
	localparam int IRQ_WIDTH      = 6;

	// Writable mask of the hub control register, bit 7 and bit 4 read as zero
	localparam logic [7:0] HUB_OC_WMASK = 8'h6F;

	// Endpoint selector codes
	localparam logic [2:0] EP_SEL_NONE = 3'h0;
	localparam logic [2:0] EP_SEL_EP1  = 3'h1;
	localparam logic [2:0] EP_SEL_EP2  = 3'h2;

	// Transfer select encoding
	localparam logic SEL_SETUP    = 1'b0;
	localparam logic SEL_FINISHED = 1'b1;

	// Pin synchroniser depth for the overcurrent inputs
	localparam int SYNC_STAGES = 3;

	// Interrupt source select register
	typedef struct packed {
		logic       tsel_b;             // Line B: finished when set, setup when clear
		logic [2:0] irq_b_endpoint_sel; // Line B source endpoint
		logic       tsel_c;             // Line C: finished when set, setup when clear
		logic [2:0] irq_c_endpoint_sel; // Line C source endpoint
	} uhp_intsel_t;

	// Hub overcurrent control register
	typedef struct packed {
		logic       rsv7;                       // Reads zero
		logic       power_enable_polarity;      // High-active enable when set
		logic       overcurrent_input_polarity; // High-active overcurrent when set
		logic       rsv4;                       // Reads zero
		logic [3:0] power_ctrl_en;              // Ports 5..2, bit 0 is port 2
	} uhp_hub_oc_t;

	// Pin group of the four downstream ports
	typedef struct packed {
		logic [3:0] o;  // Driven level
		logic [3:0] oe; // High while this block drives the pin
	} uhp_pin_drv_t;

endpackage : uhp_pkg

/* uhp_sync.sv */
// Three-stage pin synchroniser; the output moves only when stages two and three agree
module uhp_sync #(
	parameter int STAGES = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      level
);
	logic [STAGES-1:0] chain; // Stage 0 is read only by stage 1

	// Shift the raw pin through the chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain <= '0;
		end else begin
			chain <= {chain[STAGES-2:0], pin};
		end
	end

	// Accept a new level only once the last two stages agree, which filters a metastable flip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= 1'b0;
		end else if (chain[STAGES-1] == chain[STAGES-2]) begin
			level <= chain[STAGES-1];
		end
	end

endmodule : uhp_sync

/* uhp_hub_ctrl.sv */
// How it works
// - line B picks setup or finished event
// - control bit clear: general pins, set: power
// - port 3 clear keeps plain port pins
// - overcurrent polarity bit chooses active level
// - enable polarity bit chooses power-on level
//
// Design decision made here: the APB interface to the registers.
module uhp_hub_ctrl #(
	parameter int NUM_EP = 3 // Endpoint event lines, index equals endpoint number
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [15:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NUM_EP-1:0]     transfer_setup_event,
	input  wire logic [NUM_EP-1:0]     transfer_finished_event,
	output logic                       usb_irq_line_b,
	output logic                       usb_irq_line_c,
	input  wire uhp_pkg::uhp_pin_drv_t gp_enable_drv,
	input  wire logic [3:0]            port_overcurrent_pin,
	output uhp_pkg::uhp_pin_drv_t      port_power_enable_pin,
	output logic [3:0]                 overcurrent_active,
	output logic                       irq
);
	import uhp_pkg::*;

	uhp_intsel_t          intsel;     // Interrupt line selects
	uhp_hub_oc_t          hub_oc;     // Port power control
	logic [3:0]           power_on;   // Software power switch per port
	logic [IRQ_WIDTH-1:0] irq_status; // Sticky event flags
	logic [IRQ_WIDTH-1:0] irq_mask;   // Interrupt enables
	logic [3:0]           oc_level;   // Synchronised overcurrent pin levels
	logic [3:0]           next_oc_active;
	logic                 next_line_b;
	logic                 next_line_c;
	logic                 wr_en;      // Write takes effect this edge
	logic                 setup;      // Setup phase, read data is latched here
	logic                 mapped;
	logic [IRQ_WIDTH-1:0] events;
	logic [31:0]          next_rdata;

	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite && pstrb[0] && mapped;
	assign pslverr = psel && penable && !mapped;

	// Decode on the word address, low two bits ignored
	always_comb begin
		mapped = 1'b0;
		case ({paddr[15:2], 2'b00})
			ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_INTSEL, ADDR_HUB_OC, ADDR_PORT_PWR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Read mux, unmapped reads return zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case ({paddr[15:2], 2'b00})
			ADDR_IRQ_STATUS: next_rdata = {26'h0, irq_status};
			ADDR_IRQ_MASK:   next_rdata = {26'h0, irq_mask};
			ADDR_INTSEL:     next_rdata = {24'h0, intsel};
			ADDR_HUB_OC:     next_rdata = {24'h0, hub_oc};
			ADDR_PORT_PWR:   next_rdata = {24'h0, overcurrent_active, power_on};
			default:         next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so it comes out of a flip-flop during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= next_rdata;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intsel   <= RST_INTSEL;
			hub_oc   <= RST_HUB_OC;
			irq_mask <= RST_IRQ;
			power_on <= RST_PORT_PWR;
		end else if (wr_en) begin
			case ({paddr[15:2], 2'b00})
				ADDR_INTSEL:   intsel   <= pwdata[7:0];
				ADDR_HUB_OC:   hub_oc   <= pwdata[7:0] & HUB_OC_WMASK; // Reserved bits stay zero
				ADDR_IRQ_MASK: irq_mask <= pwdata[IRQ_WIDTH-1:0];
				ADDR_PORT_PWR: power_on <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Pick the event of the selected endpoint; codes without an endpoint raise nothing
	function automatic logic pick(input logic [2:0] sel, input logic fin,
			input logic [NUM_EP-1:0] ts, input logic [NUM_EP-1:0] tf);
		logic [NUM_EP-1:0] src;
		src = (fin == SEL_FINISHED) ? tf : ts;
		case (sel)
			EP_SEL_EP1: pick = src[1];
			EP_SEL_EP2: pick = src[2];
			default:    pick = 1'b0;
		endcase
	endfunction : pick

	assign next_line_b = pick(intsel.irq_b_endpoint_sel, intsel.tsel_b,
		transfer_setup_event, transfer_finished_event);
	assign next_line_c = pick(intsel.irq_c_endpoint_sel, intsel.tsel_c,
		transfer_setup_event, transfer_finished_event);

	// Request lines are one-cycle pulses, registered one edge after the event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usb_irq_line_b <= 1'b0;
			usb_irq_line_c <= 1'b0;
		end else begin
			usb_irq_line_b <= next_line_b;
			usb_irq_line_c <= next_line_c;
		end
	end

	// One synchroniser per overcurrent pin, the pins are asynchronous to pclk
	for (genvar i = 0; i < 4; i++) begin : g_sync
		uhp_sync #(
			.STAGES (SYNC_STAGES)
		) u_sync (
			.pclk    (pclk),
			.presetn (presetn),
			.pin     (port_overcurrent_pin[i]),
			.level   (oc_level[i])
		);
	end

	// Active when the pin sits at the chosen level, only on ports under hub control
	assign next_oc_active = hub_oc.power_ctrl_en & ~(oc_level ^ {4{hub_oc.overcurrent_input_polarity}});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overcurrent_active <= 4'h0;
		end else begin
			overcurrent_active <= next_oc_active;
		end
	end

	// Enable pins: general port drive when disabled, power enable at chosen polarity when enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_power_enable_pin <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (hub_oc.power_ctrl_en[i]) begin
					port_power_enable_pin.o[i]  <= ~(power_on[i] ^ hub_oc.power_enable_polarity);
					port_power_enable_pin.oe[i] <= 1'b1;
				end else begin
					port_power_enable_pin.o[i]  <= gp_enable_drv.o[i];
					port_power_enable_pin.oe[i] <= gp_enable_drv.oe[i];
				end
			end
		end
	end

	// Sticky events: line pulses and rising overcurrent
	assign events = {next_oc_active & ~overcurrent_active, next_line_c, next_line_b};

	// Set wins over a write-one clear landing on the same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= RST_IRQ;
		end else if (wr_en && ({paddr[15:2], 2'b00} == ADDR_IRQ_STATUS)) begin
			irq_status <= (irq_status & ~pwdata[IRQ_WIDTH-1:0]) | events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	// Level interrupt while any unmasked flag is set
	assign irq = |(irq_status & irq_mask);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_line_b_setup;
		(intsel.tsel_b == SEL_SETUP && intsel.irq_b_endpoint_sel == EP_SEL_EP1 && transfer_setup_event[1])
			|=> usb_irq_line_b;
	endproperty
	a_line_b_setup: assert property (p_line_b_setup) else $error("line B missed setup event");

	property p_line_b_fin_only;
		(intsel.tsel_b == SEL_FINISHED && transfer_finished_event == '0) |=> !usb_irq_line_b;
	endproperty
	a_line_b_fin_only: assert property (p_line_b_fin_only) else $error("line B raised without finished event");

	property p_line_c_fin;
		(intsel.tsel_c == SEL_FINISHED && intsel.irq_c_endpoint_sel == EP_SEL_EP2 && transfer_finished_event[2])
			|=> usb_irq_line_c ##1 irq_status[IRQ_BIT_LINE_C];
	endproperty
	a_line_c_fin: assert property (p_line_c_fin) else $error("line C missed finished event");

	property p_port2_power;
		hub_oc.power_ctrl_en[0] |=> port_power_enable_pin.oe[0]
			&& port_power_enable_pin.o[0] == ~($past(power_on[0]) ^ $past(hub_oc.power_enable_polarity));
	endproperty
	a_port2_power: assert property (p_port2_power) else $error("port 2 enable pin wrong level");

	property p_port3_general;
		!hub_oc.power_ctrl_en[1] |=> port_power_enable_pin.o[1] == $past(gp_enable_drv.o[1])
			&& port_power_enable_pin.oe[1] == $past(gp_enable_drv.oe[1]);
	endproperty
	a_port3_general: assert property (p_port3_general) else $error("port 3 not a general pin");

	property p_oc_detect;
		(hub_oc.power_ctrl_en[0] && port_overcurrent_pin[0] == hub_oc.overcurrent_input_polarity)[*6]
			|-> overcurrent_active[0];
	endproperty
	a_oc_detect: assert property (p_oc_detect) else $error("overcurrent not detected");

	property p_oc_disabled;
		!hub_oc.power_ctrl_en[2] |=> !overcurrent_active[2];
	endproperty
	a_oc_disabled: assert property (p_oc_disabled) else $error("overcurrent on disabled port");

	property p_irq_level;
		(irq_status[IRQ_BIT_LINE_B] && irq_mask[IRQ_BIT_LINE_B]) |-> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt output not raised");

	property p_w1c;
		(wr_en && {paddr[15:2], 2'b00} == ADDR_IRQ_STATUS && pwdata[IRQ_BIT_LINE_B] && !next_line_b)
			|=> !irq_status[IRQ_BIT_LINE_B];
	endproperty
	a_w1c: assert property (p_w1c) else $error("status flag not cleared");

	property p_unmapped;
		(psel && penable && !mapped) |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

	c_line_b: cover property (usb_irq_line_b ##1 irq);
	c_oc_event: cover property ($rose(overcurrent_active[3]));
	c_power_high: cover property (hub_oc.power_enable_polarity && port_power_enable_pin.o[0] && port_power_enable_pin.oe[0]);

endmodule : uhp_hub_ctrl

/* uhp_psu_model.sv */
// Behavioural external port power supply control IC, one channel per port
module uhp_psu_model (
	input  wire uhp_pkg::uhp_pin_drv_t enable_pin, // Enable pins from the block
	input  wire logic                  en_pol,     // Level that switches power on
	input  wire logic                  oc_pol,     // Level that reports overcurrent
	input  wire logic [3:0]            fault,      // Overcurrent commanded by the bench
	output logic      [3:0]            oc_pin,     // Overcurrent outputs, always driven
	output logic      [3:0]            power_on    // Supply state seen by the load
);
	timeunit 1ns;
	timeprecision 1ps;
	import uhp_pkg::*;

	// A floating enable pin never switches the supply on
	assign power_on = enable_pin.oe & ~(enable_pin.o ^ {4{en_pol}});

	// Fault reported at the chosen active level, the other level otherwise
	assign oc_pin = oc_pol ? fault : ~fault;
endmodule : uhp_psu_model

/* usb_hub_port_power_irq_select_test.sv */
// Self-checking bench for the hub power and interrupt select block
module usb_hub_port_power_irq_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	import uhp_pkg::*;

	// Table row: write, then read back
	typedef struct packed {
		logic [15:0] a; // Byte address
		logic [31:0] d; // Write data
		logic [3:0]  s; // Byte strobes
		logic [31:0] q; // Expected read
		logic        e; // Expected error
	} uhp_row_t;

	logic                pclk;
	logic                presetn   = 1'b0;
	logic                psel      = 1'b0;
	logic                penable   = 1'b0;
	logic                pwrite    = 1'b0;
	logic [15:0]         paddr     = 16'h0000;
	logic [31:0]         pwdata    = 32'h0;
	logic [3:0]          pstrb     = 4'h0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [2:0]          ts        = 3'h0;
	logic [2:0]          tf        = 3'h0;
	logic                line_b;
	logic                line_c;
	uhp_pin_drv_t        gp        = {4'hA, 4'h8}; // General drive, only port 5 enabled
	logic [3:0]          oc_pin;
	uhp_pin_drv_t        pwr_pin;
	logic [3:0]          oc_act;
	logic                irq;
	logic                en_pol    = 1'b0;
	logic                oc_pol    = 1'b0;
	logic [3:0]          fault     = 4'h0;
	logic [3:0]          power_on;
	logic [31:0]         rd_v;
	logic                err_v;
	int                  fail_count  = 0;
	int                  check_count = 0;
	int                  cycles      = 0;
	uhp_row_t            rows [7];

	uhp_hub_ctrl #(.NUM_EP(3)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .transfer_setup_event(ts), .transfer_finished_event(tf), .usb_irq_line_b(line_b),
		.usb_irq_line_c(line_c), .gp_enable_drv(gp), .port_overcurrent_pin(oc_pin),
		.port_power_enable_pin(pwr_pin), .overcurrent_active(oc_act), .irq(irq));

	uhp_psu_model psu (.enable_pin(pwr_pin), .en_pol(en_pol), .oc_pol(oc_pol), .fault(fault),
		.oc_pin(oc_pin), .power_on(power_on));

	// Clock, 4 ns period
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Hang guard, far above the expected run length
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			final_report();
		end
	end

	task final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits for pready, takes data at that edge
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v    = prdata;
		err_v   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask : wr

	task rd(input logic [15:0] a);
		apb(1'b0, a, 32'h0, 4'hF);
	endtask : rd

	// Main sequence
	initial begin
		rows[0] = {ADDR_HUB_OC, 32'hFF, 4'hF, 32'h6F, 1'b0};
		rows[1] = {ADDR_HUB_OC, 32'h00, 4'hF, 32'h00, 1'b0};
		rows[2] = {ADDR_INTSEL, 32'hA5, 4'hF, 32'hA5, 1'b0};
		rows[3] = {ADDR_INTSEL, 32'h5A, 4'h0, 32'hA5, 1'b0}; // Strobe clear, ignored
		rows[4] = {ADDR_IRQ_MASK, 32'hFF, 4'hF, 32'h3F, 1'b0};
		rows[5] = {ADDR_PORT_PWR, 32'h0A, 4'hF, 32'h0A, 1'b0};
		rows[6] = {16'hFDE4, 32'hFF, 4'hF, 32'h00, 1'b1}; // Unmapped
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
			check(err_v, rows[i].e);
			rd(rows[i].a);
			check(rd_v, rows[i].q);
		end
		$display("test registers done");
		// Every selector code, prohibited ones too, and both transfer selects; line C mirrored against line B
		wr(ADDR_IRQ_MASK, 32'h0);
		wr(ADDR_IRQ_STATUS, 32'h3F);
		for (int t = 0; t < 2; t++) for (int sb = 0; sb < 8; sb++) begin
			wr(ADDR_INTSEL, {24'h0, t[0], sb[2:0], ~t[0], 3'(3 - sb)});
			for (int ep = 1; ep < 3; ep++) for (int k = 0; k < 2; k++) begin
				@(posedge pclk);
				ts <= (k == 0) ? 3'(1 << ep) : 3'h0;
				tf <= (k == 1) ? 3'(1 << ep) : 3'h0;
				@(posedge pclk);
				ts <= 3'h0;
				tf <= 3'h0;
				@(negedge pclk);
				check(line_b, 32'(ep == sb && k == t));
				check(line_c, 32'(ep == 3 - sb && k != t));
			end
		end
		check(irq, 0);
		wr(ADDR_IRQ_MASK, 32'h03);
		@(negedge pclk);
		check(irq, 1);
		wr(ADDR_IRQ_STATUS, 32'h01);
		rd(ADDR_IRQ_STATUS);
		check(rd_v, 32'h02);
		wr(ADDR_IRQ_STATUS, 32'h02);
		@(negedge pclk);
		check(irq, 0);
		$display("test events done");
		// Ports 2 and 4 under power control, all polarity pairs
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_HUB_OC, {25'h0, p[1], p[0], 5'h05});
			en_pol <= p[1];
			oc_pol <= p[0];
			wr(ADDR_PORT_PWR, 32'h03);
			repeat (10) @(posedge pclk);
			wr(ADDR_IRQ_STATUS, 32'h3F);
			@(negedge pclk);
			check(pwr_pin.oe, 4'hD);
			check(pwr_pin.o, {1'b1, ~p[1], 1'b1, p[1]});
			check(power_on, {p[1], 3'h1});
			@(posedge pclk);
			fault <= 4'hF;
			repeat (8) @(posedge pclk);
			@(negedge pclk);
			check(oc_act, 4'h5);
			rd(ADDR_IRQ_STATUS);
			check(rd_v, 32'h14);
			fault <= 4'h0;
			repeat (8) @(posedge pclk);
			@(negedge pclk);
			check(oc_act, 4'h0);
		end
		$display("test power done");
		// Reset in mid-run
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		check(pwr_pin.oe, 4'h0);
		check(irq, 0);
		@(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_HUB_OC);
		check(rd_v, 32'h00);
		rd(ADDR_INTSEL);
		check(rd_v, 32'h00);
		$display("test reset done");
		final_report();
	end
endmodule : usb_hub_port_power_irq_select_test
